// >>> rtl/rrs_exec.sv
// Executes return, rotate-right-through-carry and standby instructions
`timescale 1ns/1ps
module rrs_exec import rrs_pkg::*; #(
	parameter int PC_W = 13
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic [13:0] instr_word,
	input wire logic [PC_W-1:0] stack_top,
	input wire logic [7:0] file_rdata,
	input wire logic carry_in,
	input wire logic wake_up,
	output logic [6:0] file_addr,
	output logic stack_pop,
	output logic [PC_W-1:0] pc,
	output logic pc_load,
	output logic [7:0] acc,
	output logic file_we,
	output logic [7:0] file_wdata,
	output logic shift_out_bit,
	output logic carry_we,
	output logic powerdown_flag,
	output logic timeout_flag,
	output logic watchdog_clear,
	output logic osc_halt,
	output logic instr_ready
);
	// Control state
	rrs_state_t state_reg;
	rrs_state_t state_next;
	// Program counter group
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	logic ld_reg;
	logic ld_next;
	// Rotate datapath group
	logic [7:0] acc_reg;
	logic [7:0] acc_next;
	logic [7:0] wdata_reg;
	logic [7:0] wdata_next;
	logic we_reg;
	logic we_next;
	logic c_reg;
	logic c_next;
	logic cwe_reg;
	logic cwe_next;
	// Status flag group
	logic pd_reg;
	logic pd_next;
	logic to_reg;
	logic to_next;
	logic wdc_reg;
	logic wdc_next;
	// Decode
	logic take;
	logic is_ret;
	logic is_rot;
	logic is_stb;
	logic ret_go;
	logic rot_go;
	logic stb_go;
	logic rot_to_file;
	logic [7:0] rot_val;

	assign take = instr_valid && instr_ready;
	assign is_ret = instr_word == RRS_OP_RETURN;
	assign is_stb = instr_word == RRS_OP_STANDBY;
	assign is_rot = instr_word[RRS_OPC_HI:RRS_OPC_LO] == RRS_OP_ROTATE;
	assign ret_go = take && is_ret;
	assign stb_go = take && is_stb;
	assign rot_go = take && is_rot;
	assign rot_to_file = instr_word[RRS_DEST_BIT];
	// Write data lags a cycle, so the register file must latch the address
	assign file_addr = instr_word[6:0];

	// Rotate through carry, one slice per bit
	generate
		for (genvar i = 0; i < 8; i++) begin : g_rot
			if (i == 7) begin : g_top
				assign rot_val[i] = carry_in;
			end else begin : g_body
				assign rot_val[i] = file_rdata[i+1];
			end
		end
	endgenerate

	// Pop is combinational so the stack unit shifts in the first cycle
	assign stack_pop = ret_go;
	// Stalls fetch during the flush cycle and the whole of sleep
	assign instr_ready = state_reg == RRS_EXEC;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RRS_EXEC: begin
				if (ret_go) begin
					state_next = RRS_FLUSH;
				end else if (stb_go) begin
					state_next = RRS_SLEEP;
				end
			end
			RRS_FLUSH: begin
				state_next = RRS_EXEC;
			end
			RRS_SLEEP: begin
				// Only a wake-up leaves sleep; fetch stays stalled meanwhile
				if (wake_up) begin
					state_next = RRS_EXEC;
				end
			end
			default: begin
				state_next = RRS_EXEC;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= RRS_EXEC;
		end else begin
			state_reg <= state_next;
		end
	end

	always_comb begin
		pc_next = pc_reg;
		ld_next = 1'b0;
		if (ret_go) begin
			pc_next = stack_top;
			ld_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= RRS_PC_RST[PC_W-1:0];
			ld_reg <= 1'b0;
		end else begin
			pc_reg <= pc_next;
			ld_reg <= ld_next;
		end
	end

	always_comb begin
		acc_next = acc_reg;
		wdata_next = wdata_reg;
		we_next = 1'b0;
		c_next = c_reg;
		cwe_next = 1'b0;
		if (rot_go) begin
			// Only carry is touched; zero and digit carry are left alone
			c_next = file_rdata[0];
			cwe_next = 1'b1;
			if (rot_to_file) begin
				wdata_next = rot_val;
				we_next = 1'b1;
			end else begin
				acc_next = rot_val;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= RRS_ACC_RST;
			wdata_reg <= RRS_ACC_RST;
			we_reg <= 1'b0;
			c_reg <= 1'b0;
			cwe_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			wdata_reg <= wdata_next;
			we_reg <= we_next;
			c_reg <= c_next;
			cwe_reg <= cwe_next;
		end
	end

	always_comb begin
		pd_next = pd_reg;
		to_next = to_reg;
		wdc_next = 1'b0;
		if (stb_go) begin
			pd_next = 1'b0;
			to_next = 1'b1;
			wdc_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_reg <= RRS_PD_RST;
			to_reg <= RRS_TO_RST;
			wdc_reg <= 1'b0;
		end else begin
			pd_reg <= pd_next;
			to_reg <= to_next;
			wdc_reg <= wdc_next;
		end
	end

	assign pc = pc_reg;
	assign pc_load = ld_reg;
	assign acc = acc_reg;
	assign file_we = we_reg;
	assign file_wdata = wdata_reg;
	assign shift_out_bit = c_reg;
	assign carry_we = cwe_reg;
	assign powerdown_flag = pd_reg;
	assign timeout_flag = to_reg;
	assign watchdog_clear = wdc_reg;
	assign osc_halt = state_reg == RRS_SLEEP;
endmodule // rrs_exec

// >>> rtl/rrs_pkg.sv
// Package with opcodes, field positions and reset values for the exec block
// Behaviour
// - Return opcode pops the stack and loads the popped top into program counter.
// - Return is one word and takes two instruction cycles.
// - Rotate right shifts operand, old carry into msb, old lsb into carry.
// - Rotate target select 0 writes accumulator, 1 writes source register.
// - Standby instruction clears the powerdown flag.
// - Standby instruction sets the timeout flag.
// - Standby clears the watchdog counter to 00h and its prescaler.
// - After standby the core sleeps with oscillator halted until wake-up.
package rrs_pkg;
	localparam logic [13:0] RRS_OP_RETURN = 14'h0008;
	localparam logic [13:0] RRS_OP_STANDBY = 14'h0063;
	localparam logic [5:0] RRS_OP_ROTATE = 6'h0c;
	localparam int RRS_OPC_HI = 13;
	localparam int RRS_OPC_LO = 8;
	localparam int RRS_DEST_BIT = 7;
	localparam logic [7:0] RRS_ACC_RST = 8'h00;
	localparam logic [12:0] RRS_PC_RST = 13'h0000;
	localparam logic RRS_PD_RST = 1'b1;
	localparam logic RRS_TO_RST = 1'b1;
	localparam logic [1:0] RRS_RETURN_CYCLES = 2'h2;
	typedef enum logic [2:0] {
		RRS_EXEC = 3'b001,
		RRS_FLUSH = 3'b010,
		RRS_SLEEP = 3'b100
	} rrs_state_t;
endpackage

// >>> verification/rrs_exec_chk.sv
// Port checker for the exec block
`timescale 1ns/1ps
module rrs_exec_chk import rrs_pkg::*; #(parameter int PC_W = 13) (
	input wire logic core_clk, rst_n, instr_valid, carry_in, wake_up,
	input wire logic [13:0] instr_word,
	input wire logic [PC_W-1:0] stack_top, pc,
	input wire logic [7:0] file_rdata, acc, file_wdata,
	input wire logic stack_pop, pc_load, file_we, shift_out_bit, carry_we,
	input wire logic powerdown_flag, timeout_flag, watchdog_clear,
	input wire logic osc_halt, instr_ready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic tk = instr_valid && instr_ready;
	wire logic ret = tk && instr_word == RRS_OP_RETURN;
	wire logic slp = tk && instr_word == RRS_OP_STANDBY;
	wire logic rot = tk && instr_word[13:8] == RRS_OP_ROTATE;
	wire logic [7:0] rr = {carry_in, file_rdata[7:1]};
	sequence s_bubble; !instr_ready ##1 instr_ready; endsequence
	property p_pop; ret |-> stack_pop; endproperty
	a_pop: assert property (p_pop) else $error("no pop");
	property p_pc; ret |=> pc_load && pc == $past(stack_top) && !carry_we;
	endproperty
	a_pc: assert property (p_pc) else $error("bad pc");
	property p_two; ret |=> s_bubble; endproperty
	a_two: assert property (p_two) else $error("bad return cycles");
	property p_cy; rot |=> carry_we && shift_out_bit == $past(file_rdata[0]);
	endproperty
	a_cy: assert property (p_cy) else $error("bad carry");
	property p_w; rot && !instr_word[7] |=> acc == $past(rr) && !file_we;
	endproperty
	a_w: assert property (p_w) else $error("bad acc");
	property p_f; rot && instr_word[7] |=> file_we && file_wdata == $past(rr);
	endproperty
	a_f: assert property (p_f) else $error("bad file write");
	property p_sl; slp |=> !powerdown_flag && timeout_flag && watchdog_clear;
	endproperty
	a_sl: assert property (p_sl) else $error("bad standby");
	property p_h; osc_halt && !wake_up |=> osc_halt && !instr_ready; endproperty
	a_h: assert property (p_h) else $error("left sleep");
	property p_one; rot |=> instr_ready; endproperty
	a_one: assert property (p_one) else $error("rotate stalled");
endmodule // rrs_exec_chk

// >>> verification/rrs_exec_bench.sv
// Directed bench for the exec block
`timescale 1ns/1ps
module rrs_exec_bench;
	import rrs_pkg::*;
	logic core_clk = 0, rst_n = 0, instr_valid = 0, carry_in = 0, wake_up = 0;
	logic [13:0] instr_word = 0;
	logic [12:0] stack_top = 0, pc;
	logic [7:0] file_rdata = 0, acc, file_wdata;
	logic [6:0] file_addr;
	logic stack_pop, pc_load, file_we, shift_out_bit, carry_we, osc_halt;
	logic powerdown_flag, timeout_flag, watchdog_clear, instr_ready;
	int fail_count = 0, comparisons = 0, cyc = 0;
	rrs_exec u_rrs_exec (.core_clk, .rst_n, .instr_valid, .instr_word,
		.stack_top, .file_rdata, .carry_in, .wake_up, .file_addr, .stack_pop,
		.pc, .pc_load, .acc, .file_we, .file_wdata, .shift_out_bit, .carry_we,
		.powerdown_flag, .timeout_flag, .watchdog_clear, .osc_halt,
		.instr_ready);
	always #25 core_clk = ~core_clk;
	// Ceiling well above the few dozen cycles the tests need
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 300) begin
			fail_count++;
			report_and_stop();
		end
	end
	task chk(input logic [15:0] s, e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task go(input logic [13:0] w, input logic [12:0] st, input logic [7:0] rd,
		input logic c);
		@(posedge core_clk);
		{instr_valid, instr_word, stack_top, file_rdata, carry_in} <= {1'b1, w, st, rd, c};
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
	endtask
	task t_ret;
		go(RRS_OP_RETURN, 13'h15a3, 8'h00, 1'b0);
		chk(pc, 16'h15a3);
		chk(instr_ready, 16'h0);
		@(posedge core_clk) #1 chk(instr_ready, 16'h1);
		$display("return test done");
	endtask
	task t_rot;
		go({RRS_OP_ROTATE, 8'h15}, 13'h0, 8'hb5, 1'b1);
		chk({acc, shift_out_bit, file_we}, 16'h36a);
		go({RRS_OP_ROTATE, 8'h95}, 13'h0, 8'h4a, 1'b0);
		chk({file_wdata, shift_out_bit, file_we, instr_ready}, 16'h12b);
		chk(acc, 16'hda);
		chk(file_addr, 16'h15);
		$display("rotate test done");
	endtask
	task t_slp;
		go(RRS_OP_STANDBY, 13'h0, 8'h00, 1'b0);
		chk({powerdown_flag, timeout_flag, watchdog_clear}, 16'h3);
		repeat (3) @(posedge core_clk);
		#1 chk({osc_halt, instr_ready}, 16'h2);
		@(posedge core_clk) wake_up <= 1'b1;
		@(posedge core_clk) wake_up <= 1'b0;
		#1 chk({osc_halt, instr_ready}, 16'h1);
		$display("standby test done");
	endtask
	task t_rst;
		@(posedge core_clk) rst_n <= 1'b0;
		@(posedge core_clk) #1;
		chk({powerdown_flag, timeout_flag, osc_halt, instr_ready}, 16'hd);
		chk(pc, 16'h0);
		chk(acc, 16'h0);
		@(posedge core_clk) rst_n <= 1'b1;
		go({RRS_OP_ROTATE, 8'h15}, 13'h0, 8'h01, 1'b0);
		chk({acc, shift_out_bit}, 16'h1);
		$display("reset test done");
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		t_ret();
		t_rot();
		t_slp();
		t_rst();
		report_and_stop();
	end
endmodule // rrs_exec_bench
bind rrs_exec rrs_exec_chk #(.PC_W(PC_W)) u_rrs_exec_chk (.core_clk, .rst_n,
	.instr_valid, .carry_in, .wake_up, .instr_word, .stack_top, .pc,
	.file_rdata, .acc, .file_wdata, .stack_pop, .pc_load, .file_we,
	.shift_out_bit, .carry_we, .powerdown_flag, .timeout_flag,
	.watchdog_clear, .osc_halt, .instr_ready);
